/* File: core/lmseq_list_mode_sequencer.sv */
// list mode sequencer with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - list and sweep never active together
// - list enable kills level loop, refuses re-enable
// - entries applied in ascending index order
// - auto mode wraps; entering it restarts
// - single waits for execute, one pass
// - step mode halts; index write moves output
// - external single starts pass on trigger edge
// - external step advances one entry per edge
// - reset returns position to range start
// - dwell used only in timed modes
// - dwell is full step period
// - only entries within start..stop processed
// - learning pass may stretch steps, flagged
// - activation learns when no stored settings
// - learn request relearns; else reuse settings
// - execute accepted only in single mode
// - trigger edge polarity selectable
module lmseq_list_mode_sequencer (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [lmseq_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [lmseq_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          externalTriggerInput,
  output logic [lmseq_pkg::FREQ_W-1:0]       entryFreq,
  output logic [lmseq_pkg::LEVEL_W-1:0]      entryLevel,
  output logic [lmseq_pkg::IDX_W-1:0]        entryIndex,
  output logic                               entryStrobe,
  output logic                               outputSettled,
  output logic                               listActive,
  output logic                               sweepActive,
  output logic                               levelLoopOn,
  output logic                               irq
);
  import lmseq_pkg::*;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        old[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return old;
  endfunction

  function automatic logic [IDX_W-1:0] stepAfter(input logic [IDX_W-1:0] p, input logic [IDX_W-1:0] lo,
                                                  input logic [IDX_W-1:0] hi);
    return (p >= hi) ? lo : p + 6'h01;
  endfunction

  // ---------------- bus slave ----------------
  logic [ADDR_W-1:0]  wrAddr;
  logic [31:0]        wrData;
  logic [3:0]         wrStrb;
  logic               awHeld;
  logic               wHeld;
  logic               wrFire;
  logic               arFire;
  logic               statusRead;
  logic [31:0]        readValue;
  logic               readOk;

  assign wrFire     = awHeld && wHeld && !s_axi_bvalid;
  assign arFire     = s_axi_arvalid && s_axi_arready;
  assign statusRead = arFire && (s_axi_araddr == REG_STATUS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      wrAddr        <= '0;
      wrData        <= '0;
      wrStrb        <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld        <= 1'b1;
        wrAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld        <= 1'b1;
        wrData       <= s_axi_wdata;
        wrStrb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrAddr[1:0] == 2'h0 && wrAddr <= REG_MASK && wrAddr != REG_STATUS) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------- configuration ----------------
  logic               sweepEn;
  logic               loopEn;
  logic               trigFalling;
  lmseq_mode_t        mode;
  logic [31:0]        dwell;
  logic [IDX_W-1:0]   rangeStart;
  logic [IDX_W-1:0]   rangeStop;
  logic [IDX_W-1:0]   entryAddr;
  logic [FREQ_W-1:0]  stagedFreq;
  logic [31:0]        mask;
  logic [31:0]        wrMerged;
  logic               wrCtrl;
  logic               wrCmd;
  logic               wrIndex;
  logic               modeChange;
  logic               execCmd;
  logic               resetCmd;
  logic               learnCmd;
  logic               entryWrite;
  logic               loopRefused;

  assign wrMerged   = mergeBytes(32'h0000_0000, wrData, wrStrb);
  assign wrCtrl     = wrFire && wrAddr == REG_CTRL;
  assign wrCmd      = wrFire && wrAddr == REG_CMD;
  assign wrIndex    = wrFire && wrAddr == REG_INDEX;
  assign modeChange = wrFire && wrAddr == REG_MODE && wrMerged[2:0] <= 3'(MODE_EXT_STEP)
                      && wrMerged[2:0] != 3'(mode);
  assign execCmd    = wrCmd && wrMerged[CMD_EXEC] && mode == MODE_SINGLE;
  assign resetCmd   = wrCmd && wrMerged[CMD_RESET];
  assign learnCmd   = wrCmd && wrMerged[CMD_LEARN];
  assign entryWrite = wrFire && wrAddr == REG_ELEVEL;
  assign loopRefused = wrCtrl && wrMerged[CTRL_LOOP] && (listActive || wrMerged[CTRL_LIST]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      listActive  <= 1'b0;
      sweepEn     <= 1'b0;
      loopEn      <= 1'b0;
      trigFalling <= 1'b0;
    end else if (wrCtrl) begin
      // enabling one of list and sweep drops the other
      listActive  <= wrMerged[CTRL_LIST];
      sweepEn     <= wrMerged[CTRL_SWEEP] && !wrMerged[CTRL_LIST];
      loopEn      <= wrMerged[CTRL_LOOP] && !wrMerged[CTRL_LIST] && !listActive;
      trigFalling <= wrMerged[CTRL_FALLING];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode       <= MODE_AUTO;
      dwell      <= DWELL_RST;
      rangeStart <= '0;
      rangeStop  <= STOP_RST;
      entryAddr  <= '0;
      stagedFreq <= '0;
      mask       <= '0;
    end else if (wrFire) begin
      case (wrAddr)
        REG_MODE: begin
          if (modeChange) begin
            mode <= lmseq_mode_t'(wrMerged[2:0]);
          end
        end
        REG_DWELL:  dwell <= mergeBytes(dwell, wrData, wrStrb);
        REG_RANGE: begin
          rangeStart <= wrMerged[IDX_W-1:0];
          rangeStop  <= wrMerged[RANGE_STOP +: IDX_W];
        end
        REG_EADDR:  entryAddr <= wrMerged[IDX_W-1:0];
        REG_EFREQ:  stagedFreq <= mergeBytes(stagedFreq, wrData, wrStrb);
        REG_MASK:   mask <= mergeBytes(mask, wrData, wrStrb);
        default: begin
        end
      endcase
    end
  end

  // ---------------- list memory ----------------
  logic [FREQ_W-1:0]  freqMem [LIST_DEPTH];
  logic [LEVEL_W-1:0] levelMem [LIST_DEPTH];

  always_ff @(posedge clk) begin
    if (entryWrite) begin
      freqMem[entryAddr]  <= stagedFreq;
      levelMem[entryAddr] <= wrMerged[LEVEL_W-1:0];
    end
  end

  // ---------------- external trigger ----------------
  logic trigSync1;
  logic trigSync2;
  logic trigLast;
  logic trigEdge;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trigSync1 <= 1'b0;
      trigSync2 <= 1'b0;
      trigLast  <= 1'b0;
    end else begin
      trigSync1 <= externalTriggerInput;
      trigSync2 <= trigSync1;
      trigLast  <= trigSync2;
    end
  end

  assign trigEdge = trigFalling ? (trigLast && !trigSync2) : (!trigLast && trigSync2);

  // ---------------- sequencer ----------------
  logic [IDX_W-1:0]   pos;
  logic               running;
  logic               learning;
  logic               learned;
  logic [31:0]        dwellCnt;
  logic [31:0]        stepLen;
  logic [7:0]         settleCnt;
  logic               listWasOn;
  logic               activation;
  logic               stepEnd;
  logic               passEnd;
  logic               stretched;
  logic               load;
  logic [IDX_W-1:0]   next_pos;
  logic               next_running;
  logic               indexOk;

  assign activation = listActive && !listWasOn;
  assign stretched  = learning && dwell < LEARN_CYC;
  assign stepLen    = stretched ? LEARN_CYC : ((dwell == 32'h0) ? 32'h1 : dwell);
  assign stepEnd    = running && dwellCnt >= stepLen - 32'h1;
  assign passEnd    = stepEnd && pos >= rangeStop;
  assign indexOk    = wrMerged[IDX_W-1:0] >= rangeStart && wrMerged[IDX_W-1:0] <= rangeStop;

  always_comb begin
    next_pos     = pos;
    next_running = running;
    load         = 1'b0;
    if (!listActive) begin
      next_running = 1'b0;
    end else if (activation || resetCmd) begin
      next_pos     = rangeStart;
      next_running = (mode == MODE_AUTO);
      load         = 1'b1;
    end else if (modeChange) begin
      next_pos     = rangeStart;
      next_running = (wrMerged[2:0] == 3'(MODE_AUTO));
      load         = (wrMerged[2:0] == 3'(MODE_AUTO));
    end else if (execCmd || (mode == MODE_EXT_SINGLE && trigEdge && !running)) begin
      next_pos     = rangeStart;
      next_running = 1'b1;
      load         = 1'b1;
    end else if (mode == MODE_EXT_STEP && trigEdge) begin
      next_pos = stepAfter(pos, rangeStart, rangeStop);
      load     = 1'b1;
    end else if (mode == MODE_STEP && wrIndex && indexOk) begin
      next_pos = wrMerged[IDX_W-1:0];
      load     = 1'b1;
    end else if (stepEnd) begin
      if (passEnd && mode != MODE_AUTO) begin
        next_running = 1'b0;
      end else begin
        next_pos = stepAfter(pos, rangeStart, rangeStop);
        load     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos       <= '0;
      running   <= 1'b0;
      listWasOn <= 1'b0;
      dwellCnt  <= '0;
    end else begin
      pos       <= next_pos;
      running   <= next_running;
      listWasOn <= listActive;
      dwellCnt  <= (load || !running) ? 32'h0 : dwellCnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      learned  <= 1'b0;
      learning <= 1'b0;
    end else if (entryWrite || learnCmd) begin
      learned  <= 1'b0;
      learning <= learnCmd;
    end else if (activation && !learned) begin
      learning <= 1'b1;
    end else if (learning && (passEnd || (load && pos >= rangeStop))) begin
      learning <= 1'b0;
      learned  <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      entryFreq     <= '0;
      entryLevel    <= '0;
      entryIndex    <= '0;
      entryStrobe   <= 1'b0;
      settleCnt     <= '0;
      outputSettled <= 1'b0;
      sweepActive   <= 1'b0;
      levelLoopOn   <= 1'b0;
    end else begin
      entryStrobe <= load;
      if (load) begin
        entryFreq  <= freqMem[next_pos];
        entryLevel <= levelMem[next_pos];
        entryIndex <= next_pos;
      end
      settleCnt     <= load ? 8'h00 : ((settleCnt == 8'hFF) ? settleCnt : settleCnt + 8'h01);
      outputSettled <= !load && (32'(settleCnt) >= SETTLE_CYC - 32'h1);
      // follow the enables in the same cycle so list and sweep never overlap
      sweepActive   <= wrCtrl ? (wrMerged[CTRL_SWEEP] && !wrMerged[CTRL_LIST]) : sweepEn;
      levelLoopOn   <= wrCtrl ? (wrMerged[CTRL_LOOP] && !wrMerged[CTRL_LIST] && !listActive) : loopEn;
    end
  end

  // ---------------- status and interrupt ----------------
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] events;

  always_comb begin
    events               = '0;
    events[ST_DONE]      = passEnd && mode != MODE_AUTO && listActive;
    events[ST_DEVIATION] = stepEnd && stretched;
    events[ST_REFUSED]   = loopRefused;
    events[ST_LEARNED]   = learning && passEnd;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= (statusRead ? '0 : status) | events;
      irq    <= |(status & mask[ST_W-1:0]);
    end
  end

  always_comb begin
    readOk = 1'b1;
    case (s_axi_araddr)
      REG_CTRL:   readValue = {28'h0, trigFalling, loopEn, sweepEn, listActive};
      REG_MODE:   readValue = {29'h0, mode};
      REG_CMD:    readValue = 32'h0;
      REG_DWELL:  readValue = dwell;
      REG_RANGE:  readValue = {10'h0, rangeStop, 10'h0, rangeStart};
      REG_INDEX:  readValue = {26'h0, pos};
      REG_EADDR:  readValue = {26'h0, entryAddr};
      REG_EFREQ:  readValue = stagedFreq;
      REG_ELEVEL: readValue = 32'h0;
      REG_STATUS: readValue = {28'h0, status};
      REG_MASK:   readValue = mask;
      REG_STATE:  readValue = {28'h0, learned, learning, running, listActive};
      default: begin
        readValue = 32'h0;
        readOk    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'h0;
    end else if (arFire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readValue;
      s_axi_rresp   <= readOk ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- checks ----------------
  sequence seqWrap;
    stepEnd && pos >= rangeStop && mode == MODE_AUTO && !resetCmd && !modeChange && listActive;
  endsequence

  chk_list_sweep_excl: assert property (@(posedge clk) disable iff (!rst_b) !(listActive && sweepActive))
    else $error("list and sweep active together");
  chk_loop_blocked: assert property (@(posedge clk) disable iff (!rst_b) listActive |=> !levelLoopOn)
    else $error("level loop on while list active");
  sequence seqTimedStart;
    $rose(running) && !stretched && dwell == 32'h3;
  endsequence

  sequence seqUndisturbed;
    (running && !wrFire && !trigEdge) [*3];
  endsequence

  chk_auto_wrap: assert property (@(posedge clk) disable iff (!rst_b)
      seqWrap |=> pos == rangeStart && entryStrobe)
    else $error("auto mode did not wrap");
  chk_single_wait: assert property (@(posedge clk) disable iff (!rst_b)
      modeChange && wrMerged[2:0] == 3'(MODE_SINGLE) |=> !running [*2])
    else $error("single mode started without execute");
  chk_index_move: assert property (@(posedge clk) disable iff (!rst_b)
      listActive && !listWasOn == 1'b0 && mode == MODE_STEP && wrIndex && indexOk && !resetCmd
      |=> pos == $past(wrMerged[IDX_W-1:0]) ##1 entryIndex == $past(pos))
    else $error("index write did not move output");
  chk_ext_step: assert property (@(posedge clk) disable iff (!rst_b)
      listWasOn && listActive && mode == MODE_EXT_STEP && trigEdge && !wrFire
      |=> pos == stepAfter($past(pos), rangeStart, rangeStop))
    else $error("external step did not advance one entry");
  chk_reset_pos: assert property (@(posedge clk) disable iff (!rst_b)
      listActive && resetCmd |=> pos == rangeStart)
    else $error("reset did not return to range start");
  chk_no_timed_step: assert property (@(posedge clk) disable iff (!rst_b)
      mode == MODE_STEP || mode == MODE_EXT_STEP |-> !running)
    else $error("dwell timer running in step mode");
  chk_exec_gate: assert property (@(posedge clk) disable iff (!rst_b)
      wrCmd && wrMerged[CMD_EXEC] && mode != MODE_SINGLE && !running && !trigEdge && mode != MODE_AUTO
      |=> !running)
    else $error("execute accepted outside single mode");
  // a three cycle dwell must end its first step on the fourth edge
  chk_dwell_period: assert property (@(posedge clk) disable iff (!rst_b)
      seqTimedStart ##0 seqUndisturbed |=> entryStrobe || !running)
    else $error("step period differs from dwell");
endmodule // lmseq_list_mode_sequencer

/* File: core/lmseq_pkg.sv */
// constants and types of the list mode sequencer
package lmseq_pkg;
  localparam int          IDX_W      = 6;
  localparam int          LIST_DEPTH = 64;
  localparam int          FREQ_W     = 32;
  localparam int          LEVEL_W    = 16;
  localparam int          ADDR_W     = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MODE   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CMD    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DWELL  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_RANGE  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_INDEX  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_EADDR  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_EFREQ  = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_ELEVEL = 8'h20;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] REG_MASK   = 8'h28;
  localparam logic [ADDR_W-1:0] REG_STATE  = 8'h2C;

  // field positions
  localparam int CTRL_LIST    = 0;
  localparam int CTRL_SWEEP   = 1;
  localparam int CTRL_LOOP    = 2;
  localparam int CTRL_FALLING = 3;
  localparam int CMD_EXEC     = 0;
  localparam int CMD_RESET    = 1;
  localparam int CMD_LEARN    = 2;
  localparam int RANGE_STOP   = 16;
  localparam int ST_DONE      = 0;
  localparam int ST_DEVIATION = 1;
  localparam int ST_REFUSED   = 2;
  localparam int ST_LEARNED   = 3;
  localparam int ST_W         = 4;

  // reset values
  localparam logic [31:0]      DWELL_RST = 32'h0000_03E8;
  localparam logic [IDX_W-1:0] STOP_RST  = 6'h3F;

  // timing
  localparam int          CLK_NS     = 10;
  localparam int          SETTLE_NS  = 1000;
  localparam int          LEARN_NS   = 2000;
  localparam logic [31:0] SETTLE_CYC = 32'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] LEARN_CYC  = 32'((LEARN_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    MODE_AUTO, MODE_SINGLE, MODE_STEP, MODE_EXT_SINGLE, MODE_EXT_STEP
  } lmseq_mode_t;
endpackage

/* File: sim/lmseq_far_side.sv */
// far side model: source of the external trigger pin
`timescale 1ns/1ps
module lmseq_far_side (
  input  wire logic clk,
  output logic      trigPin
);
  logic idleHigh = 1'b0;

  initial trigPin = 1'b0;

  // leaving the idle level is the active edge
  task setIdle(input logic high);
    idleHigh = high;
    trigPin <= high;
    repeat (4) @(posedge clk);
  endtask

  // one pulse; the caller's spacing sets the step length
  task fire();
    trigPin <= ~idleHigh;
    repeat (4) @(posedge clk);
    trigPin <= idleHigh;
    repeat (4) @(posedge clk);
  endtask
endmodule // lmseq_far_side

/* File: sim/list_mode_sequencer_test.sv */
// self-checking bench of the list mode sequencer
`timescale 1ns/1ps
module list_mode_sequencer_test;
  import lmseq_pkg::*;
  typedef struct { logic [IDX_W-1:0] idx; int gap; } lmseq_note_t;
  localparam int STEP = 60;
  localparam int LIMIT = 20000;

  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              quiet = 1'b0;
  logic [31:0]       wdata = '0;
  logic [31:0]       seed = 32'h0000_0049;
  logic              awready, wready, bvalid, arready, rvalid, trig, strobe, settled;
  logic              listOn, sweepOn, loopOn, irq;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata, freq;
  logic [15:0]       level;
  logic [5:0]        idx;
  logic [31:0]       freqs [8];
  logic [15:0]       levels [8];
  int                bad_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                last = 0;
  lmseq_note_t       notes [$];
  lmseq_note_t       note;

  initial forever #5 clk = ~clk;

  lmseq_list_mode_sequencer DUT (
    .clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .externalTriggerInput(trig), .entryFreq(freq), .entryLevel(level), .entryIndex(idx),
    .entryStrobe(strobe), .outputSettled(settled), .listActive(listOn),
    .sweepActive(sweepOn), .levelLoopOn(loopOn), .irq(irq)
  );

  lmseq_far_side far (.clk(clk), .trigPin(trig));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task check(input string what, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      awDone = awDone | (awready === 1'b1);
      wDone = wDone | (wready === 1'b1);
      if (awDone) awvalid <= 1'b0;
      if (wDone) wvalid <= 1'b0;
    end while (!(awDone && wDone));
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(resp));
    @(posedge clk);
  endtask

  task rdc(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] w, input logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("read data", rdata & m, w);
    check("rresp", 32'(rresp), 32'(resp));
    @(posedge clk);
  endtask

  task want(input int i, input int g);
    notes.push_back('{6'(i), g});
  endtask

  task finishTest(input string name);
    while (notes.size() != 0) @(posedge clk);
    $display("test %s ended", name);
  endtask

  // synthesis side: each applied entry is taken against the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      summarize();
    end
    if (rst_b === 1'b1 && strobe === 1'b1) begin
      if (notes.size() == 0) begin
        if (!quiet) check("extra strobe index", 32'(idx), 32'h0000_00FF);
      end else begin
        note = notes.pop_front();
        check("index", 32'(idx), 32'(note.idx));
        check("freq", freq, freqs[note.idx]);
        check("level", 32'(level), 32'(levels[note.idx]));
        if (note.gap != 0) check("step length", 32'(cyc - last), 32'(note.gap));
      end
      last = cyc;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(REG_DWELL, 32'hFFFF_FFFF, DWELL_RST, 2'h0);
    rdc(REG_RANGE, 32'hFFFF_FFFF, 32'(STOP_RST) << RANGE_STOP, 2'h0);
    rdc(8'hFC, 32'hFFFF_FFFF, 32'h0, 2'h2);
    wr(REG_STATUS, 32'h0, 2'h2);
    for (int i = 0; i < 8; i++) begin
      freqs[i] = rnd();
      levels[i] = 16'(rnd());
      wr(REG_EADDR, 32'(i), 2'h0);
      wr(REG_EFREQ, freqs[i], 2'h0);
      wr(REG_ELEVEL, 32'(levels[i]), 2'h0);
    end
    wr(REG_RANGE, 32'h0004_0001, 2'h0);
    wr(REG_DWELL, 32'(STEP), 2'h0);
    wr(REG_CTRL, 32'h6, 2'h0);
    check("sweep on", 32'(sweepOn), 32'h1);
    check("loop on", 32'(loopOn), 32'h1);
    for (int p = 0; p < 2; p++) for (int i = 1; i < 5; i++) want(i, i == 1 ? 0 : (p == 0 ? int'(LEARN_CYC) : STEP));
    wr(REG_CTRL, 32'h1, 2'h0);
    check("sweep off", 32'(sweepOn), 32'h0);
    check("loop off", 32'(loopOn), 32'h0);
    finishTest("auto");
    wr(REG_MODE, 32'h1, 2'h0);
    rdc(REG_STATUS, 32'hA, 32'hA, 2'h0);
    wr(REG_CTRL, 32'h5, 2'h0);
    check("loop refused", 32'(loopOn), 32'h0);
    check("irq masked", 32'(irq), 32'h0);
    wr(REG_MASK, 32'h4, 2'h0);
    check("irq raised", 32'(irq), 32'h1);
    rdc(REG_STATUS, 32'h4, 32'h4, 2'h0);
    @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    repeat (50) @(posedge clk);
    for (int i = 1; i < 5; i++) want(i, i == 1 ? 0 : STEP);
    wr(REG_CMD, 32'h1, 2'h0);
    finishTest("single");
    repeat (100) @(posedge clk);
    check("held index", 32'(idx), 32'h4);
    rdc(REG_STATUS, 32'h1, 32'h1, 2'h0);
    wr(REG_MODE, 32'h2, 2'h0);
    wr(REG_CMD, 32'h1, 2'h0);
    want(3, 0);
    wr(REG_INDEX, 32'h3, 2'h0);
    finishTest("step");
    repeat (int'(SETTLE_CYC) + 2) @(posedge clk);
    check("settled", 32'(settled), 32'h1);
    quiet <= 1'b1;
    wr(REG_CMD, 32'h2, 2'h0);
    rdc(REG_INDEX, 32'h3F, 32'h1, 2'h0);
    wr(REG_MODE, 32'h4, 2'h0);
    quiet <= 1'b0;
    for (int i = 2; i < 6; i++) want(i % 4 == 1 ? 1 : i, i == 2 ? 0 : 30);
    repeat (4) begin
      far.fire();
      repeat (22) @(posedge clk);
    end
    finishTest("external step");
    wr(REG_MODE, 32'h3, 2'h0);
    wr(REG_CTRL, 32'h9, 2'h0);
    far.setIdle(1'b1);
    repeat (20) @(posedge clk);
    for (int i = 1; i < 5; i++) want(i, i == 1 ? 0 : STEP);
    far.fire();
    finishTest("external single");
    wr(REG_DWELL, 32'h3, 2'h0);
    want(1, 0);
    want(2, 3);
    wr(REG_MODE, 32'h0, 2'h0);
    finishTest("auto restart");
    quiet <= 1'b1;
    wr(REG_CTRL, 32'h2, 2'h0);
    check("list off", 32'(listOn), 32'h0);
    check("sweep back", 32'(sweepOn), 32'h1);
    summarize();
  end
endmodule // list_mode_sequencer_test
